/* File: dv/fsk_exec_monitor.sv */
// port checker for the flag-skip execution unit
`timescale 1ns/1ps
module fsk_exec_monitor import fsk_pkg::*; (
  // watched ports
  input wire logic i_clk,
  input wire logic i_rst,
  input wire fsk_req_t i_req,
  input wire fsk_flags_t i_flags,
  input wire logic i_ext_lcd_en,
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic o_illegal,
  input wire logic o_pc_load,
  input wire logic [PC_W-1:0] o_pc,
  input wire logic o_spi_sclk,
  input wire logic o_spi_mosi,
  input wire logic o_spi_active
);
  logic iss;
  logic [PC_W-1:0] pc1;
  fsk_op_t op;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  assign iss = i_req.valid && !o_busy;
  assign op = i_req.op;
  assign pc1 = i_req.pc + 16'h1;
  a_neg_untaken: assert property (iss && op == OP_SKIP_IF_NEGATIVE && !i_flags.sign
    |=> o_done && o_pc == $past(pc1)) else $error("negative skip taken on clear sign");
  a_pos_untaken: assert property (iss && op == OP_SKIP_IF_NONNEGATIVE && i_flags.sign
    |=> o_done && o_pc == $past(pc1)) else $error("nonnegative skip taken on set sign");
  a_ovc_untaken: assert property (iss && op == OP_SKIP_IF_OVERFLOW_CLEAR && i_flags.overflow
    |=> o_done && o_pc == $past(pc1)) else $error("overflow clear skip taken");
  a_ovs_untaken: assert property (iss && op == OP_SKIP_IF_OVERFLOW_SET && !i_flags.overflow
    |=> o_done && o_pc == $past(pc1)) else $error("overflow set skip taken");
  a_skip_one_cycle: assert property (iss && op == OP_SKIP_IF_NEGATIVE && i_flags.sign && i_req.count == 2'h1
    |=> !o_done ##1 o_done) else $error("single skip timing wrong");
  a_done_pc_load: assert property (o_done |-> o_pc_load && !o_busy) else $error("done without pc load");
  a_lcd_refused: assert property (iss && op == OP_LCD_VALUE_TO_SERIAL && !i_ext_lcd_en
    |=> o_illegal && o_done && !o_spi_active) else $error("serial send without lcd mode");
  a_lcd_frame: assert property (iss && op == OP_LCD_VALUE_TO_SERIAL && i_ext_lcd_en && i_req.nbits == 5'h01
    |=> ##1 o_spi_active) else $error("frame did not start");
  a_serial_idle: assert property (!o_spi_active |-> !o_spi_sclk && !o_spi_mosi) else $error("serial not idle");
endmodule // fsk_exec_monitor

/* File: dv/fsk_lcd_model.sv */
// lcd controller model sampling the serial line
`timescale 1ns/1ps
module fsk_lcd_model (
  // serial side
  input wire logic i_sclk,
  input wire logic i_mosi,
  input wire logic i_active,
  // last captured frame
  output logic [23:0] o_word,
  output logic [4:0] o_nbits
);
  logic [23:0] sh = 24'h000000;
  logic [4:0] n = 5'h00;
  // mode 0: bits taken on rising sclk, frame closes when active drops
  always @(posedge i_sclk or negedge i_active) begin
    if (!i_active) begin
      o_word <= sh;
      o_nbits <= n;
      sh <= 24'h000000;
      n <= 5'h00;
    end else begin
      sh <= {sh[22:0], i_mosi};
      n <= n + 5'h01;
    end
  end
endmodule // fsk_lcd_model

/* File: dv/tb_top.sv */
// self-checking bench for the flag-skip execution unit
`timescale 1ns/1ps
module tb_top;
  import fsk_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  fsk_req_t req = '0;
  fsk_flags_t flg = '0;
  logic [23:0] acc = 24'hA5C396;
  logic lcd_en = 1'b0;
  logic [2:0] flen;
  logic busy, done, ill, pcl, sclk, mosi, act;
  logic [15:0] pc, fad;
  logic [23:0] word;
  logic [4:0] nb;
  int err_count = 0;
  int compares = 0;
  initial begin
    forever #50 i_clk = ~i_clk;
  end
  // instruction length rom stand-in, lengths 1..4
  assign flen = fad[1:0] + 3'h1;
  fsk_exec #(.HALF(1)) dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_req(req), .i_flags(flg), .i_fetch_len(flen),
    .i_accu_y(acc), .i_ext_lcd_en(lcd_en), .o_busy(busy), .o_done(done), .o_illegal(ill), .o_pc_load(pcl),
    .o_pc(pc), .o_fetch_addr(fad), .o_spi_sclk(sclk), .o_spi_mosi(mosi), .o_spi_active(act));
  fsk_lcd_model lcd_u (.i_sclk(sclk), .i_mosi(mosi), .i_active(act), .o_word(word), .o_nbits(nb));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH t=%0t seen %0h exp %0h", $time, s, e);
    end
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // one issue, returns cycles from issue edge to done
  task automatic run(input fsk_op_t op, input int c, input int n, input logic [15:0] p, input int f,
      output int cyc);
    @(posedge i_clk);
    req <= '{1'b1, op, 2'(c), 5'(n), p};
    flg <= fsk_flags_t'(2'(f));
    @(posedge i_clk);
    req.valid <= 1'b0;
    cyc = 1;
    #1;
    while (done !== 1'b1) begin
      if (cyc > 200) begin
        err_count++;
        summarize();
      end
      @(posedge i_clk);
      #1;
      cyc++;
    end
  endtask
  task automatic t_skips();
    logic tk;
    logic [15:0] p, e;
    int cyc;
    for (int k = 1; k < 5; k++) begin
      for (int f = 0; f < 4; f++) begin
        for (int c = 1; c < 4; c++) begin
          p = 16'(16'h1000 + k * 64 + f * 16 + c);
          tk = (k == 1) ? f[1] : (k == 2) ? !f[1] : (k == 3) ? !f[0] : f[0];
          e = p + 16'h1;
          if (tk) begin
            repeat (c) e = e + 16'(e[1:0]) + 16'h1;
          end
          run(fsk_op_t'(k), c, 1, p, f, cyc);
          chk(pc, e);
          chk({pcl, busy}, 2'b10);
          chk(cyc, tk ? c + 1 : 1);
          chk(ill, 0);
        end
      end
    end
    $display("t_skips finished");
  endtask
  task automatic t_illegal();
    int cyc;
    run(OP_SKIP_IF_NEGATIVE, 0, 1, 16'h2000, 2, cyc);
    chk({ill, pc}, {1'b1, 16'h2001});
    for (int i = 0; i < 3; i++) begin
      @(posedge i_clk);
      lcd_en <= (i != 0);
      run(OP_LCD_VALUE_TO_SERIAL, 1, (i == 0) ? 8 : (i == 1) ? 0 : 25, 16'h2100, 0, cyc);
      chk({ill, act, 6'(cyc)}, {2'b10, 6'h01});
    end
    $display("t_illegal finished");
  endtask
  task automatic t_lcd();
    int cyc;
    int n;
    for (int i = 0; i < 3; i++) begin
      n = (i == 0) ? 1 : (i == 1) ? 8 : 24;
      @(posedge i_clk);
      lcd_en <= 1'b1;
      run(OP_LCD_VALUE_TO_SERIAL, 1, n, 16'h3000, 0, cyc);
      // start is registered twice and done once more after the frame
      chk(cyc, 2 * n + 3);
      chk({ill, pc}, {1'b0, 16'h3007});
      chk(nb, n);
      chk(word, 32'(acc) & ((32'h1 << n) - 32'h1));
    end
    $display("t_lcd finished");
  endtask
  initial begin
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    t_skips();
    t_illegal();
    t_lcd();
    summarize();
  end
endmodule // tb_top
bind fsk_exec fsk_exec_monitor mon_u (.i_clk(i_clk), .i_rst(i_rst), .i_req(i_req), .i_flags(i_flags),
  .i_ext_lcd_en(i_ext_lcd_en), .o_busy(o_busy), .o_done(o_done), .o_illegal(o_illegal), .o_pc_load(o_pc_load),
  .o_pc(o_pc), .o_spi_sclk(o_spi_sclk), .o_spi_mosi(o_spi_mosi), .o_spi_active(o_spi_active));

/* File: src/fsk_exec.sv */
// execution unit for the flag-skip instructions and the lcd value serial send
//
// What this block does
// - skip_if_negative skips next count instructions when sign flag is 1.
// - skip_if_nonnegative skips next count instructions when sign flag is 0.
// - skip_if_overflow_clear skips when overflow flag is 0, else none skipped.
// - skip_if_overflow_set skips when overflow flag is 1, else none skipped.
// - taken skip adds byte lengths of next count instructions; count is 1..3.
// - skip costs one own cycle plus one per skipped instruction.
// - lcd_value_to_serial sends accumulator y over the serial port to the lcd.
// - second operand sets how many accumulator bits are shifted out.
// - lcd serial send works only when external lcd mode is configured.
`timescale 1ns/1ps
module fsk_exec import fsk_pkg::*; #(
  parameter int AW = ACC_W,
  parameter int PW = PC_W,
  parameter int HALF = SPI_HALF_CYC
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // instruction issue from the sequencer
  input wire fsk_req_t i_req,
  input wire fsk_flags_t i_flags,
  // instruction length lookup at o_fetch_addr
  input wire logic [LEN_W-1:0] i_fetch_len,
  // lcd serial source and configuration
  input wire logic [AW-1:0] i_accu_y,
  input wire logic i_ext_lcd_en,
  // sequencer results
  output logic o_busy,
  output logic o_done,
  output logic o_illegal,
  output logic o_pc_load,
  output logic [PW-1:0] o_pc,
  output logic [PW-1:0] o_fetch_addr,
  // serial port toward the lcd controller
  output logic o_spi_sclk,
  output logic o_spi_mosi,
  output logic o_spi_active
);

  if (PW != PC_W) begin : g_chk_pw
    $error("fsk_exec: PW must match PC_W of the request struct");
  end
  if (AW < 1 || AW > int'(NBITS_MAX)) begin : g_chk_aw
    $error("fsk_exec: AW out of range");
  end

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SKIP,
    ST_SHIFT
  } fsk_state_t;

  typedef struct packed {
    fsk_state_t state;
    logic busy;
    logic done;
    logic illegal;
    logic pc_load;
    logic [PW-1:0] pc;
    logic [PW-1:0] addr;
    logic [CNT_W-1:0] remain;
    logic spi_start;
    logic [NBITS_W-1:0] spi_nbits;
    logic [AW-1:0] spi_data;
  } fsk_exec_state_t;

  fsk_exec_state_t st_ff;
  fsk_exec_state_t nxt_st;

  logic is_skip;
  logic cond;
  logic count_ok;
  logic nbits_ok;
  logic [PW-1:0] pc_after_skip_op;
  logic [PW-1:0] pc_after_lcd_op;
  logic [PW-1:0] addr_next;
  logic sh_busy;
  logic sh_done;

  // flags are only read here, never written back
  always_comb begin
    is_skip = 1'b0;
    cond = 1'b0;
    case (i_req.op)
      OP_SKIP_IF_NEGATIVE: begin
        is_skip = 1'b1;
        cond = (i_flags.sign == SIGN_NEGATIVE);
      end
      OP_SKIP_IF_NONNEGATIVE: begin
        is_skip = 1'b1;
        cond = (i_flags.sign == SIGN_NONNEGATIVE);
      end
      OP_SKIP_IF_OVERFLOW_CLEAR: begin
        is_skip = 1'b1;
        cond = (i_flags.overflow == OVF_CLEAR);
      end
      OP_SKIP_IF_OVERFLOW_SET: begin
        is_skip = 1'b1;
        cond = (i_flags.overflow == OVF_SET);
      end
      default: begin
        is_skip = 1'b0;
        cond = 1'b0;
      end
    endcase
  end

  assign count_ok = (i_req.count >= SKIP_CNT_MIN) && (i_req.count <= SKIP_CNT_MAX);
  assign nbits_ok = (i_req.nbits >= NBITS_MIN) && (int'(i_req.nbits) <= AW);
  assign pc_after_skip_op = i_req.pc + PW'(SKIP_OP_BYTES);
  assign pc_after_lcd_op = i_req.pc + PW'(LCD_OP_BYTES);
  assign addr_next = st_ff.addr + PW'(i_fetch_len);

  always_comb begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    nxt_st.illegal = 1'b0;
    nxt_st.pc_load = 1'b0;
    nxt_st.spi_start = 1'b0;
    case (st_ff.state)
      ST_IDLE: begin
        // a request while busy is not looked at; the sequencer waits for done
        if (i_req.valid && is_skip) begin
          if (!count_ok) begin
            // bad count: treat as not taken and report it
            nxt_st.illegal = 1'b1;
            nxt_st.pc = pc_after_skip_op;
            nxt_st.pc_load = 1'b1;
            nxt_st.done = 1'b1;
          end else if (cond) begin
            nxt_st.state = ST_SKIP;
            nxt_st.busy = 1'b1;
            nxt_st.addr = pc_after_skip_op;
            nxt_st.remain = i_req.count;
          end else begin
            nxt_st.pc = pc_after_skip_op;
            nxt_st.pc_load = 1'b1;
            nxt_st.done = 1'b1;
          end
        end else if (i_req.valid && i_req.op == OP_LCD_VALUE_TO_SERIAL) begin
          if (!i_ext_lcd_en || !nbits_ok) begin
            nxt_st.illegal = 1'b1;
            nxt_st.pc = pc_after_lcd_op;
            nxt_st.pc_load = 1'b1;
            nxt_st.done = 1'b1;
          end else begin
            nxt_st.state = ST_SHIFT;
            nxt_st.busy = 1'b1;
            nxt_st.pc = pc_after_lcd_op;
            nxt_st.spi_start = 1'b1;
            nxt_st.spi_nbits = i_req.nbits;
            nxt_st.spi_data = i_accu_y;
          end
        end
      end
      ST_SKIP: begin
        // one cycle per passed-over instruction to learn its length
        nxt_st.addr = addr_next;
        nxt_st.remain = st_ff.remain - CNT_W'(1);
        if (st_ff.remain == SKIP_CNT_LAST) begin
          nxt_st.state = ST_IDLE;
          nxt_st.busy = 1'b0;
          nxt_st.pc = addr_next;
          nxt_st.pc_load = 1'b1;
          nxt_st.done = 1'b1;
        end
      end
      ST_SHIFT: begin
        // sequencer stays stalled for the whole frame so accu y is not reused early
        if (sh_done) begin
          nxt_st.state = ST_IDLE;
          nxt_st.busy = 1'b0;
          nxt_st.pc_load = 1'b1;
          nxt_st.done = 1'b1;
        end
      end
      default: begin
        nxt_st.state = ST_IDLE;
        nxt_st.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  fsk_serial_shift #(
    .W(AW),
    .HALF(HALF)
  ) u_shift (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_start(st_ff.spi_start),
    .i_data(st_ff.spi_data),
    .i_nbits(st_ff.spi_nbits),
    .o_sclk(o_spi_sclk),
    .o_mosi(o_spi_mosi),
    .o_busy(sh_busy),
    .o_done(sh_done)
  );

  assign o_busy = st_ff.busy;
  assign o_done = st_ff.done;
  assign o_illegal = st_ff.illegal;
  assign o_pc_load = st_ff.pc_load;
  assign o_pc = st_ff.pc;
  assign o_fetch_addr = st_ff.addr;
  assign o_spi_active = sh_busy;

endmodule // fsk_exec

/* File: src/fsk_pkg.sv */
// constants and types shared by the flag-skip and lcd serial execution logic
package fsk_pkg;

  // widths
  localparam int ACC_W = 24;
  localparam int PC_W = 16;
  localparam int LEN_W = 3;
  localparam int CNT_W = 2;
  localparam int NBITS_W = 5;

  // skip count operand range
  localparam logic [CNT_W-1:0] SKIP_CNT_MIN = 2'h1;
  localparam logic [CNT_W-1:0] SKIP_CNT_MAX = 2'h3;
  localparam logic [CNT_W-1:0] SKIP_CNT_LAST = 2'h1;

  // flag levels that make a skip taken
  localparam logic SIGN_NEGATIVE = 1'b1;
  localparam logic SIGN_NONNEGATIVE = 1'b0;
  localparam logic OVF_CLEAR = 1'b0;
  localparam logic OVF_SET = 1'b1;

  // instruction byte lengths
  localparam int SKIP_OP_BYTES = 1;
  localparam int LCD_OP_BYTES = 7;

  // serial bit count operand range
  localparam logic [NBITS_W-1:0] NBITS_MIN = 5'h01;
  localparam logic [NBITS_W-1:0] NBITS_MAX = 5'h18;

  // serial clock timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int SPI_HALF_NS = 500;
  localparam int SPI_HALF_CYC_RAW = (SPI_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SPI_HALF_CYC = (SPI_HALF_CYC_RAW < 1) ? 1 : SPI_HALF_CYC_RAW;
  localparam int DIV_W = 8;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_SKIP_IF_NEGATIVE,
    OP_SKIP_IF_NONNEGATIVE,
    OP_SKIP_IF_OVERFLOW_CLEAR,
    OP_SKIP_IF_OVERFLOW_SET,
    OP_LCD_VALUE_TO_SERIAL
  } fsk_op_t;

  typedef struct packed {
    logic valid;
    fsk_op_t op;
    logic [CNT_W-1:0] count;
    logic [NBITS_W-1:0] nbits;
    logic [PC_W-1:0] pc;
  } fsk_req_t;

  typedef struct packed {
    logic sign;
    logic overflow;
  } fsk_flags_t;

endpackage

/* File: src/fsk_serial_shift.sv */
// serial shifter that sends the low bits of an accumulator value msb first
`timescale 1ns/1ps
module fsk_serial_shift import fsk_pkg::*; #(
  parameter int W = ACC_W,
  parameter int HALF = SPI_HALF_CYC
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // transfer request
  input wire logic i_start,
  input wire logic [W-1:0] i_data,
  input wire logic [NBITS_W-1:0] i_nbits,
  // serial side
  output logic o_sclk,
  output logic o_mosi,
  output logic o_busy,
  output logic o_done
);

  if (W < 1 || W > (1 << NBITS_W) - 1) begin : g_chk_w
    $error("fsk_serial_shift: W out of range");
  end
  if (HALF < 1 || HALF > (1 << DIV_W)) begin : g_chk_half
    $error("fsk_serial_shift: HALF out of range");
  end

  typedef struct packed {
    logic busy;
    logic done;
    logic sclk;
    logic mosi;
    logic [DIV_W-1:0] div;
    logic [NBITS_W-1:0] left;
    logic [W-1:0] sh;
  } fsk_sh_state_t;

  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(HALF - 1);

  fsk_sh_state_t st_ff;
  fsk_sh_state_t nxt_st;
  logic [W-1:0] aligned;

  always_comb begin
    aligned = i_data << (W - int'(i_nbits));
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    if (!st_ff.busy) begin
      if (i_start) begin
        // left-align so the top of the selected field goes first
        nxt_st.busy = 1'b1;
        nxt_st.sh = aligned;
        nxt_st.mosi = aligned[W-1];
        nxt_st.sclk = 1'b0;
        nxt_st.div = '0;
        nxt_st.left = i_nbits;
      end
    end else if (st_ff.div == DIV_LAST) begin
      nxt_st.div = '0;
      if (!st_ff.sclk) begin
        nxt_st.sclk = 1'b1;
      end else begin
        nxt_st.sclk = 1'b0;
        nxt_st.left = st_ff.left - NBITS_W'(1);
        if (st_ff.left == NBITS_W'(1)) begin
          nxt_st.busy = 1'b0;
          nxt_st.done = 1'b1;
          nxt_st.mosi = 1'b0;
        end else begin
          nxt_st.sh = st_ff.sh << 1;
          nxt_st.mosi = st_ff.sh[W-2];
        end
      end
    end else begin
      nxt_st.div = st_ff.div + DIV_W'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_sclk = st_ff.sclk;
  assign o_mosi = st_ff.mosi;
  assign o_busy = st_ff.busy;
  assign o_done = st_ff.done;

endmodule // fsk_serial_shift
